// [verilog/mptc_pkg.sv]
// Package of constants for the motor pulse timer and capture block
package mptc_pkg;
    // ********************
    // Register addresses
    // ********************
    localparam logic [15:0] ADDR_CMP_HIGH = 16'h0FDE;
    localparam logic [15:0] ADDR_CMP_LOW = 16'h0FDF;
    localparam logic [15:0] ADDR_CAP_HIGH = 16'h0FE2;
    localparam logic [15:0] ADDR_CAP_LOW = 16'h0FE3;
    localparam logic [15:0] ADDR_TIMER_CONTROL_STATUS = 16'h0FE4;
    localparam logic [15:0] ADDR_NOISE_WIDTH_CONTROL = 16'h0FE5;

    // ********************
    // Control/status field positions
    // ********************
    localparam int TIMER_CONTROL_STATUS_CLR = 7;
    localparam int TIMER_CONTROL_STATUS_MODE = 6;
    localparam int TIMER_CONTROL_STATUS_FLAG = 5;
    localparam int TIMER_CONTROL_STATUS_IRQEN = 4;
    localparam int TIMER_CONTROL_STATUS_RUN = 3;
    localparam int TIMER_CONTROL_STATUS_CKS_LSB = 0;
    localparam int NOISE_WIDTH_CONTROL_POS2_LSB = 6;
    localparam int NOISE_WIDTH_CONTROL_POS1_LSB = 4;
    localparam int NOISE_WIDTH_CONTROL_POS0_LSB = 2;
    localparam int NOISE_WIDTH_CONTROL_ESTOP_LSB = 0;

    // ********************
    // Reset values and widths
    // ********************
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [15:0] COUNT_ZERO = 16'h0000;
    localparam logic [15:0] COUNT_ONE = 16'h0001;
    localparam logic [2:0] CKS_RESET = 3'h0;
    localparam logic [7:0] NOISE_WIDTH_CONTROL_RESET = 8'h00;
    localparam int PRESC_W = 7;
    localparam logic [4:0] FILT_MIN_N = 5'h02;

    // Overflow value of an n-bit filter counter, n = 2 + width
    function automatic logic [4:0] mptc_filt_limit(input logic [1:0] width);
        logic [5:0] pow;
        pow = 6'h01 << (FILT_MIN_N + {3'h0, width});
        return pow[4:0] - 5'h01;
    endfunction

    // Prescaler mask for a divide by two to the power of sel
    function automatic logic [PRESC_W-1:0] mptc_presc_mask(input logic [2:0] sel);
        logic [PRESC_W:0] pow;
        pow = 8'h01 << sel;
        return pow[PRESC_W-1:0] - 7'h01;
    endfunction
endpackage

// [verilog/mptc_prescaler.sv]
// Count clock tick generator with selectable division
`timescale 1ns/100ps
module mptc_prescaler (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic [2:0] sel_i,
    output logic tick_o
);
    import mptc_pkg::*;

    typedef struct packed {
        logic [PRESC_W-1:0] cnt;
        logic tick;
    } mptc_presc_type;

    mptc_presc_type st;
    mptc_presc_type next_st;

    // A new selection takes effect at once, with no resync of the divider
    always_comb begin
        next_st = st;
        next_st.cnt = st.cnt + 7'h01;
        next_st.tick = (st.cnt & mptc_presc_mask(sel_i)) == mptc_presc_mask(sel_i);
    end

    // State register
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign tick_o = st.tick;
endmodule

// [verilog/mptc_noise_filter.sv]
// Noise filter with a 2 to 5 bit acceptance counter for one pin input
`timescale 1ns/100ps
module mptc_noise_filter #(
    parameter logic RESET_LEVEL = 1'b0
) (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic en_i,
    input wire logic [1:0] width_i,
    input wire logic raw_i,
    output logic filt_o
);
    import mptc_pkg::*;

    typedef struct packed {
        logic sync1;
        logic sync2;
        logic [4:0] cnt;
        logic filt;
    } mptc_filt_type;

    mptc_filt_type st;
    mptc_filt_type next_st;

    // With en_i high, new level accepted only after the counter overflows while it holds; with en_i low, sync2 passes straight through
    always_comb begin
        next_st = st;
        next_st.sync1 = raw_i;
        next_st.sync2 = st.sync1;
        if (!en_i) begin
            next_st.filt = st.sync2;
            next_st.cnt = 5'h00;
        end else if (st.sync2 != st.filt) begin
            if (st.cnt == mptc_filt_limit(width_i)) begin
                next_st.filt = st.sync2;
                next_st.cnt = 5'h00;
            end else begin
                next_st.cnt = st.cnt + 5'h01;
            end
        end else begin
            next_st.cnt = 5'h00;
        end
    end

    // State register
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            st <= '0;
            st.filt <= RESET_LEVEL;
            // Synchronisers start at the idle level, so no false change follows reset
            st.sync1 <= RESET_LEVEL;
            st.sync2 <= RESET_LEVEL;
        end else begin
            st <= next_st;
        end
    end

    assign filt_o = st.filt;

    a_filt_short: assert property (@(posedge clk_i) disable iff (!nrst_i)
        (en_i && st.filt != st.sync2 && st.cnt != mptc_filt_limit(width_i))
        |=> $stable(st.filt))
        else $error("filter accepted a level before overflow");
endmodule

// [verilog/mptc_timer.sv]
// Free-running 16-bit timer with capture, compare clear and input filters
// What this block does
// - On trigger, copy the count into capture buffer, then clear the counter.
// - Capture bytes are read-only; writes ignored; content after reset zero.
// - Counter-clear bit reads zero; writing one zeroes the counter.
// - Mode bit selects write-timing (0) or position-detect (1) as trigger.
// - Trigger reset is applied at the next count-change point.
// - Count equal to compare value clears counter and sets compare flag.
// - Flag cleared by writing zero; one ignored; read-modify-write reads one.
// - Interrupt request asserted only while flag and enable are both one.
// - Run enable bit starts counting at one, stops at zero.
// - Compare matching is suspended while the timer is stopped.
// - Count clock select takes effect immediately; change it while stopped.
// - Each position input has its own 2-bit noise width field.
// - Emergency-stop input has its own 2-bit noise width field.
// - Filter counts n bits, n from 2 to 5, accepting input on overflow.
// - Compare value held in two writable bytes; match zeroes the counter.
`timescale 1ns/100ps
module mptc_timer (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic [15:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic rmw_i,
    input wire logic write_timing_i,
    input wire logic pos_detect_i,
    input wire logic [2:0] position_inputs_i,
    input wire logic emergency_stop_input_i,
    input wire logic [3:0] filter_en_i,
    output logic [7:0] rdata_o,
    output logic compare_clear_irq_o,
    output logic [2:0] position_filtered_o,
    output logic estop_filtered_o
);
    import mptc_pkg::*;

    // ********************
    // State
    // ********************
    typedef struct packed {
        logic [15:0] count;
        logic [15:0] capture;
        logic [7:0] low_latch;
        logic [7:0] cmp_high;
        logic [7:0] cmp_low;
        logic mode;
        logic flag;
        logic irq_en;
        logic run;
        logic [2:0] cks;
        logic [7:0] noise_width_control;
        logic pend;
        logic [7:0] rdata;
        logic irq;
    } mptc_state_type;

    mptc_state_type st;
    mptc_state_type next_st;
    logic tick;
    logic trig;
    logic pend_now;
    logic clr_wr;
    logic step;
    logic match;

    // ********************
    // Count clock
    // ********************
    // The tick is registered, so a new select acts one edge late; keep the
    // select steady for an edge before the timer is started
    mptc_prescaler u_presc (
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .sel_i(st.cks),
        .tick_o(tick)
    );

    // ********************
    // Noise filters
    // ********************
    // Each filter synchronises its pin, then counts; a bypassed filter
    // still adds the two synchroniser edges and its output flop
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi = gi + 1) begin : g_pos
            mptc_noise_filter #(.RESET_LEVEL(1'b0)) u_filt (
                .clk_i(clk_i),
                .nrst_i(nrst_i),
                .en_i(filter_en_i[gi]),
                .width_i(st.noise_width_control[NOISE_WIDTH_CONTROL_POS0_LSB + 2*gi +: 2]),
                .raw_i(position_inputs_i[gi]),
                .filt_o(position_filtered_o[gi])
            );
        end
    endgenerate

    // Emergency stop idles high, being active low
    mptc_noise_filter #(.RESET_LEVEL(1'b1)) u_estop (
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .en_i(filter_en_i[3]),
        .width_i(st.noise_width_control[NOISE_WIDTH_CONTROL_ESTOP_LSB +: 2]),
        .raw_i(emergency_stop_input_i),
        .filt_o(estop_filtered_o)
    );

    // ********************
    // Event decode
    // ********************
    // Trigger source chosen by mode; count step only on a tick while running
    assign trig = st.mode ? pos_detect_i : write_timing_i;
    assign pend_now = st.pend | trig;
    assign clr_wr = wr_i && addr_i == ADDR_TIMER_CONTROL_STATUS && wdata_i[TIMER_CONTROL_STATUS_CLR];
    assign step = st.run && tick;
    assign match = step && st.count == {st.cmp_high, st.cmp_low};

    // ********************
    // Next state
    // ********************
    always_comb begin
        next_st = st;
        // Register writes; capture bytes have no write path
        if (wr_i) begin
            case (addr_i)
                ADDR_CMP_HIGH: begin
                    next_st.cmp_high = wdata_i;
                end
                ADDR_CMP_LOW: begin
                    next_st.cmp_low = wdata_i;
                end
                ADDR_TIMER_CONTROL_STATUS: begin
                    next_st.mode = wdata_i[TIMER_CONTROL_STATUS_MODE];
                    next_st.irq_en = wdata_i[TIMER_CONTROL_STATUS_IRQEN];
                    next_st.run = wdata_i[TIMER_CONTROL_STATUS_RUN];
                    next_st.cks = wdata_i[TIMER_CONTROL_STATUS_CKS_LSB +: 3];
                    if (!wdata_i[TIMER_CONTROL_STATUS_FLAG]) begin
                        next_st.flag = 1'b0;
                    end
                end
                ADDR_NOISE_WIDTH_CONTROL: begin
                    next_st.noise_width_control = wdata_i;
                end
                // Capture bytes are read-only; a write leaves them alone
                ADDR_CAP_HIGH, ADDR_CAP_LOW: begin
                    next_st.capture = st.capture;
                end
                // Unmapped writes are ignored
                default: begin
                    next_st.noise_width_control = st.noise_width_control;
                end
            endcase
        end
        // Counter: clear write, then trigger, then compare, then increment
        next_st.pend = pend_now;
        if (clr_wr) begin
            next_st.count = COUNT_ZERO;
        end else if (step && pend_now) begin
            next_st.capture = st.count;
            next_st.count = COUNT_ZERO;
            next_st.pend = 1'b0;
        end else if (match) begin
            next_st.count = COUNT_ZERO;
        end else if (step) begin
            next_st.count = st.count + COUNT_ONE;
        end
        // Hardware set wins over a software clear in the same cycle
        if (match) begin
            next_st.flag = 1'b1;
        end
        next_st.irq = next_st.flag && next_st.irq_en;
        // Read data, one cycle after the strobe
        if (rd_i) begin
            case (addr_i)
                ADDR_CAP_HIGH: begin
                    next_st.rdata = st.capture[15:8];
                    next_st.low_latch = st.capture[7:0];
                end
                ADDR_CAP_LOW: begin
                    next_st.rdata = st.low_latch;
                end
                ADDR_CMP_HIGH: begin
                    next_st.rdata = st.cmp_high;
                end
                ADDR_CMP_LOW: begin
                    next_st.rdata = st.cmp_low;
                end
                ADDR_TIMER_CONTROL_STATUS: begin
                    next_st.rdata = {1'b0, st.mode, st.flag | rmw_i, st.irq_en,
                        st.run, st.cks};
                end
                ADDR_NOISE_WIDTH_CONTROL: begin
                    next_st.rdata = st.noise_width_control;
                end
                default: begin
                    next_st.rdata = BYTE_ZERO;
                end
            endcase
        end
    end

    // ********************
    // State register
    // ********************
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            st <= '0;
            st.cks <= CKS_RESET;
            st.noise_width_control <= NOISE_WIDTH_CONTROL_RESET;
        end else begin
            st <= next_st;
        end
    end

    assign rdata_o = st.rdata;
    assign compare_clear_irq_o = st.irq;

    // ********************
    // Assertions
    // ********************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!nrst_i);

    // Capture, clear and counting
    a_trig_capture: assert property ((step && pend_now && !clr_wr) |=>
        (st.capture == $past(st.count) && st.count == COUNT_ZERO))
        else $error("trigger did not capture and clear");
    a_capture_ro: assert property ((wr_i && !(step && pend_now)) |=>
        $stable(st.capture))
        else $error("capture changed without a trigger");
    a_clear_write: assert property (clr_wr |=> st.count == COUNT_ZERO)
        else $error("clear write did not zero counter");
    a_trig_wait: assert property ((pend_now && !step && !clr_wr && !match) |=>
        (st.pend && $stable(st.count)))
        else $error("trigger acted between count points");
    a_count_inc: assert property ((step && !pend_now && !match && !clr_wr) |=>
        st.count == $past(st.count) + COUNT_ONE)
        else $error("counter did not step by one");
    a_wrap_zero: assert property ((step && !pend_now && !match && !clr_wr
        && st.count == '1) |=> st.count == COUNT_ZERO)
        else $error("counter did not wrap to zero");

    // Trigger source selection
    a_mode_select: assert property ((!st.pend && !st.mode && pos_detect_i
        && !write_timing_i) |=> !st.pend)
        else $error("position strobe taken in write-timing mode");
    a_mode_guard: assert property ((!st.pend && st.mode && write_timing_i
        && !pos_detect_i) |=> !st.pend)
        else $error("write-timing strobe taken in position mode");

    // Compare clear and its flag
    a_match_flag: assert property (match && !clr_wr |=>
        (st.flag && st.count == COUNT_ZERO))
        else $error("compare match did not clear and flag");
    a_flag_clear: assert property ((wr_i && addr_i == ADDR_TIMER_CONTROL_STATUS
        && !wdata_i[TIMER_CONTROL_STATUS_FLAG] && !match) |=> !st.flag)
        else $error("flag not cleared by zero write");
    a_flag_hold: assert property ((st.flag && !(wr_i && addr_i == ADDR_TIMER_CONTROL_STATUS
        && !wdata_i[TIMER_CONTROL_STATUS_FLAG])) |=> st.flag)
        else $error("flag dropped without a zero write");
    a_rmw_flag: assert property ((rd_i && rmw_i && addr_i == ADDR_TIMER_CONTROL_STATUS) |=>
        rdata_o[TIMER_CONTROL_STATUS_FLAG] && !rdata_o[TIMER_CONTROL_STATUS_CLR])
        else $error("read-modify-write flag read wrong");
    a_irq_gate: assert property (compare_clear_irq_o == (st.flag && st.irq_en))
        else $error("interrupt request not flag and enable");
    a_stop_hold: assert property ((!st.run && !clr_wr) |=> $stable(st.count))
        else $error("counter moved while stopped");
    a_stop_no_match: assert property ((!st.run && !st.flag) |=> !st.flag)
        else $error("compare flag set while stopped");

    // Register reads and writes
    a_clear_reads: assert property ((rd_i && addr_i == ADDR_TIMER_CONTROL_STATUS) |=>
        !rdata_o[TIMER_CONTROL_STATUS_CLR])
        else $error("clear bit did not read zero");
    a_run_write: assert property ((wr_i && addr_i == ADDR_TIMER_CONTROL_STATUS) |=>
        st.run == $past(wdata_i[TIMER_CONTROL_STATUS_RUN]))
        else $error("run enable not taken from write");
    a_mode_write: assert property ((wr_i && addr_i == ADDR_TIMER_CONTROL_STATUS) |=>
        st.mode == $past(wdata_i[TIMER_CONTROL_STATUS_MODE]))
        else $error("trigger source not taken from write");
    a_cap_upper: assert property ((rd_i && addr_i == ADDR_CAP_HIGH) |=>
        rdata_o == $past(st.capture[15:8]))
        else $error("upper capture byte read wrong");
    a_low_latch: assert property ((rd_i && addr_i == ADDR_CAP_HIGH) ##1
        (rd_i && addr_i == ADDR_CAP_LOW) |=> rdata_o == $past(st.capture[7:0], 2))
        else $error("lower byte not coherent with upper");
    a_cks_write: assert property ((wr_i && addr_i == ADDR_TIMER_CONTROL_STATUS) |=>
        st.cks == $past(wdata_i[TIMER_CONTROL_STATUS_CKS_LSB +: 3]))
        else $error("clock select not taken at once");
    a_width_write: assert property ((wr_i && addr_i == ADDR_NOISE_WIDTH_CONTROL) |=>
        st.noise_width_control == $past(wdata_i))
        else $error("noise width byte not taken");
    a_cmp_write: assert property ((wr_i && addr_i == ADDR_CMP_LOW) |=>
        st.cmp_low == $past(wdata_i))
        else $error("compare low byte not taken");
    a_cmp_upper: assert property ((wr_i && addr_i == ADDR_CMP_HIGH) |=>
        st.cmp_high == $past(wdata_i))
        else $error("compare high byte not taken");

    // Main scenarios
    c_capture: cover property (step && pend_now ##1 rd_i && addr_i == ADDR_CAP_HIGH);
    c_match: cover property (match ##1 compare_clear_irq_o);
    c_wrap: cover property (step && st.count == 16'hFFFF && !match && !pend_now);
    c_trig_stopped: cover property (trig && !st.run);
    c_rmw_read: cover property (rd_i && rmw_i && st.flag);
endmodule

// [tb/mptc_source_model.sv]
// Model of the trigger units and the pins that feed the timer
`timescale 1ns/100ps
module mptc_source_model (
    input wire logic clk_i,
    output logic write_timing_o,
    output logic pos_detect_o,
    output logic [2:0] position_o,
    output logic estop_o
);
    // Idle levels: no trigger, position pins low, stop pin high
    initial begin
        write_timing_o = 1'b0;
        pos_detect_o = 1'b0;
        position_o = 3'h0;
        estop_o = 1'b1;
    end

    // One-cycle strobe from the write-timing or the position-detect unit
    task automatic fire(input logic pos);
        if (pos) begin
            pos_detect_o = 1'b1;
        end else begin
            write_timing_o = 1'b1;
        end
        @(posedge clk_i);
        #10;
        pos_detect_o = 1'b0;
        write_timing_o = 1'b0;
    endtask

    // Drive one pin level: 0..2 position pins, 3 the stop pin
    task automatic pin(input int idx, input logic lvl);
        if (idx == 3) begin
            estop_o = lvl;
        end else begin
            position_o[idx] = lvl;
        end
    endtask
endmodule

// [tb/testbench.sv]
// Self-checking testbench for the motor pulse timer and capture block
`timescale 1ns/100ps
module testbench;
    import mptc_pkg::*;
    logic clk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic [15:0] addr_i = 16'h0000;
    logic [7:0] wdata_i = 8'h00;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic rmw_i = 1'b0;
    logic wt;
    logic pd;
    logic estop;
    logic [2:0] position;
    logic [7:0] rdata;
    logic irq;
    logic [2:0] pos_filt;
    logic estop_filt;
    logic [7:0] ctl = 8'h20;
    logic [3:0] fen = 4'hF;
    logic [15:0] v;
    int failures = 0;
    int comparisons = 0;

    // Clock of 100 ns period
    always #50 clk_i = ~clk_i;

    mptc_timer mptc_timer_inst (.clk_i(clk_i), .nrst_i(nrst_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rmw_i(rmw_i), .write_timing_i(wt),
        .pos_detect_i(pd), .position_inputs_i(position), .emergency_stop_input_i(estop),
        .filter_en_i(fen), .rdata_o(rdata), .compare_clear_irq_o(irq),
        .position_filtered_o(pos_filt), .estop_filtered_o(estop_filt));
    mptc_source_model mptc_source_model_inst (.clk_i(clk_i), .write_timing_o(wt),
        .pos_detect_o(pd), .position_o(position), .estop_o(estop));

    // ********************
    // Shared tasks
    // ********************
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic op(input logic w, r, m, input logic [15:0] a, input logic [7:0] d);
        wr_i = w;
        rd_i = r;
        rmw_i = m;
        addr_i = a;
        wdata_i = d;
        @(posedge clk_i);
        #10;
    endtask
    task automatic idle(input int n);
        wr_i = 1'b0;
        rd_i = 1'b0;
        rmw_i = 1'b0;
        repeat (n) begin
            @(posedge clk_i);
            #10;
        end
    endtask
    task automatic rchk(input logic [15:0] a, input logic [7:0] exp, input logic m);
        op(1'b0, 1'b1, m, a, 8'h00);
        chk(16'(rdata), 16'(exp));
    endtask
    // Count for n edges; the clock select is set while stopped, an edge before the start
    task automatic run_for(input int n, input logic [2:0] cks);
        op(1'b1, 1'b0, 1'b0, ADDR_TIMER_CONTROL_STATUS, ctl | {5'h00, cks});
        op(1'b1, 1'b0, 1'b0, ADDR_TIMER_CONTROL_STATUS, ctl | 8'h08 | {5'h00, cks});
        if (n > 1) idle(n - 1);
        op(1'b1, 1'b0, 1'b0, ADDR_TIMER_CONTROL_STATUS, ctl | {5'h00, cks});
        idle(1);
    endtask
    // Pending trigger, one count edge, then upper byte first
    task automatic grab(input logic [15:0] exp);
        mptc_source_model_inst.fire(ctl[6]);
        run_for(1, 3'h0);
        op(1'b0, 1'b1, 1'b0, ADDR_CAP_HIGH, 8'h00);
        v[15:8] = rdata;
        op(1'b0, 1'b1, 1'b0, ADDR_CAP_LOW, 8'h00);
        v[7:0] = rdata;
        idle(1);
        chk(v, exp);
    endtask
    function automatic logic fval(input int i);
        return (i == 3) ? estop_filt : pos_filt[i];
    endfunction

    // ********************
    // Scenarios
    // ********************
    task automatic t_regs();
        rchk(ADDR_TIMER_CONTROL_STATUS, 8'h00, 1'b0);
        rchk(ADDR_NOISE_WIDTH_CONTROL, NOISE_WIDTH_CONTROL_RESET, 1'b0);
        rchk(16'h0FE6, 8'h00, 1'b0);
        op(1'b1, 1'b0, 1'b0, ADDR_CMP_HIGH, 8'hFF);
        op(1'b1, 1'b0, 1'b0, ADDR_CMP_LOW, 8'hFF);
        rchk(ADDR_CMP_HIGH, 8'hFF, 1'b0);
        rchk(ADDR_CMP_LOW, 8'hFF, 1'b0);
        idle(1);
        $display("Test registers finished");
    endtask
    task automatic t_count();
        grab(16'h0000);
        run_for(37, 3'h0);
        grab(16'h0025);
        for (int c = 1; c < 8; c++) begin
            run_for(128, c[2:0]);
            grab(16'h0080 >> c);
        end
        // Strobe of the unselected source leaves the count alone
        mptc_source_model_inst.fire(1'b1);
        run_for(3, 3'h0);
        grab(16'h0003);
        ctl = 8'h60;
        op(1'b1, 1'b0, 1'b0, ADDR_TIMER_CONTROL_STATUS, ctl);
        idle(1);
        mptc_source_model_inst.fire(1'b0);
        run_for(5, 3'h0);
        grab(16'h0005);
        ctl = 8'h20;
        $display("Test counting finished");
    endtask
    task automatic t_capture();
        run_for(300, 3'h0);
        grab(16'h012C);
        rchk(ADDR_CAP_HIGH, 8'h01, 1'b0);
        idle(1);
        mptc_source_model_inst.fire(1'b0);
        run_for(1, 3'h0);
        op(1'b1, 1'b0, 1'b0, ADDR_CAP_HIGH, 8'hFF);
        op(1'b1, 1'b0, 1'b0, ADDR_CAP_LOW, 8'hFF);
        rchk(ADDR_CAP_LOW, 8'h2C, 1'b0);
        rchk(ADDR_CAP_HIGH, 8'h00, 1'b0);
        idle(1);
        run_for(20, 3'h0);
        op(1'b1, 1'b0, 1'b0, ADDR_TIMER_CONTROL_STATUS, ctl | 8'h80);
        rchk(ADDR_TIMER_CONTROL_STATUS, 8'h00, 1'b0);
        idle(1);
        grab(16'h0000);
        $display("Test capture finished");
    endtask
    task automatic t_compare();
        ctl = 8'h30;
        op(1'b1, 1'b0, 1'b0, ADDR_CMP_HIGH, 8'h00);
        op(1'b1, 1'b0, 1'b0, ADDR_CMP_LOW, 8'h05);
        run_for(20, 3'h0);
        chk(16'(irq), 16'h0001);
        rchk(ADDR_TIMER_CONTROL_STATUS, 8'h30, 1'b0);
        idle(1);
        grab(16'h0002);
        op(1'b1, 1'b0, 1'b0, ADDR_TIMER_CONTROL_STATUS, 8'h10);
        op(1'b1, 1'b0, 1'b0, ADDR_TIMER_CONTROL_STATUS, 8'h30);
        op(1'b1, 1'b0, 1'b0, ADDR_CMP_LOW, 8'h00);
        idle(4);
        chk(16'(irq), 16'h0000);
        rchk(ADDR_TIMER_CONTROL_STATUS, 8'h10, 1'b0);
        rchk(ADDR_TIMER_CONTROL_STATUS, 8'h30, 1'b1);
        ctl = 8'h20;
        op(1'b1, 1'b0, 1'b0, ADDR_CMP_LOW, 8'h05);
        run_for(20, 3'h0);
        chk(16'(irq), 16'h0000);
        rchk(ADDR_TIMER_CONTROL_STATUS, 8'h20, 1'b0);
        op(1'b1, 1'b0, 1'b0, ADDR_TIMER_CONTROL_STATUS, 8'h00);
        op(1'b1, 1'b0, 1'b0, ADDR_CMP_HIGH, 8'hFF);
        op(1'b1, 1'b0, 1'b0, ADDR_CMP_LOW, 8'hFF);
        idle(1);
        $display("Test compare finished");
    endtask
    // Widths 0..3 on pos0, pos1, pos2 and the stop pin in that order
    task automatic t_filter();
        int n;
        logic act;
        op(1'b1, 1'b0, 1'b0, ADDR_NOISE_WIDTH_CONTROL, 8'h93);
        rchk(ADDR_NOISE_WIDTH_CONTROL, 8'h93, 1'b0);
        idle(1);
        for (int i = 0; i < 4; i++) begin
            n = 1 << (2 + i);
            act = (i != 3);
            mptc_source_model_inst.pin(i, act);
            idle(n - 1);
            mptc_source_model_inst.pin(i, ~act);
            repeat (n + 6) begin
                idle(1);
                chk(16'(fval(i)), 16'(!act));
            end
            mptc_source_model_inst.pin(i, act);
            idle(n + 6);
            chk(16'(fval(i)), 16'(act));
            mptc_source_model_inst.pin(i, ~act);
            idle(n + 6);
            chk(16'(fval(i)), 16'(!act));
        end
        // A bypassed filter follows the synchronised pin after three edges
        fen = 4'hE;
        mptc_source_model_inst.pin(0, 1'b1);
        idle(3);
        chk(16'(pos_filt[0]), 16'h0001);
        mptc_source_model_inst.pin(0, 1'b0);
        idle(3);
        chk(16'(pos_filt[0]), 16'h0000);
        fen = 4'hF;
        $display("Test filters finished");
    endtask

    task automatic give_verdict();
        $display("Comparisons %0d, failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // Main sequence after three reset cycles
    initial begin
        repeat (3) @(posedge clk_i);
        #10;
        nrst_i = 1'b1;
        t_regs();
        t_count();
        t_capture();
        t_compare();
        t_filter();
        give_verdict();
    end

    // Watchdog well beyond the expected run of about 1800 cycles
    initial begin
        #(20000 * 100);
        failures++;
        give_verdict();
    end
endmodule
